/* include/ppfm_defs.svh */
// Purpose: offsets, field positions and reset values of the port pin function mux
// Assumes: 32-bit AHB-Lite register slave, one aligned word per register
// Notes: byte addresses; unmapped addresses read zero
`ifndef PPFM_DEFS_SVH
`define PPFM_DEFS_SVH

`define PPFM_PINS 16
`define PPFM_OFF_OUT 8'h00
`define PPFM_OFF_IN 8'h04
`define PPFM_OFF_CTRL_LO 8'h08
`define PPFM_OFF_CTRL_HI 8'h0C
`define PPFM_OFF_HWSEL 8'h10
`define PPFM_FSEL_W 3
`define PPFM_FSEL_STRIDE 4
// output enable bit within each pin's control field
`define PPFM_FSEL_OE_BIT 3
`define PPFM_HWSEL_W 2
// pin 1 is preset to the debug master after reset
`define PPFM_DEBUG_PIN 1
`define PPFM_HWSEL_RST 32'h0000_0008
`define PPFM_CTRL_RST 32'h0000_0000
`define PPFM_OUT_RST 16'h0000

`endif

/* include/ppfm_pkg.sv */
// Purpose: types of the port pin function mux
// Assumes: ppfm_defs.svh defines the widths
// Notes: none
`default_nettype none
package ppfm_pkg;
    // pin function select codes
    typedef enum logic [2:0] {
        PPFM_FN_GPIO = 3'h0,
        PPFM_FN_ALTERNATE_OUTPUT_ONE = 3'h1,
        PPFM_FN_ALT2 = 3'h2,
        PPFM_FN_ALT3 = 3'h3,
        PPFM_FN_ALT4 = 3'h4
    } ppfm_fn_t;
    // hardware master select codes
    typedef enum logic [1:0] {
        PPFM_HW_NONE = 2'h0,
        PPFM_HW_MASTER0 = 2'h1,
        PPFM_HW_MASTER1 = 2'h2
    } ppfm_hw_t;
    // one hardware master's drive of all pins
    typedef struct packed {
        logic [15:0] value;
        logic [15:0] enable;
    } ppfm_hw_drive_t;
    // one set of pad drive signals
    typedef struct packed {
        logic [15:0] value;
        logic [15:0] enable;
    } ppfm_pad_t;
endpackage : ppfm_pkg
`default_nettype wire

/* src/ppfm_port_mux.sv */
// Purpose: per-pin output/input multiplexing of a 16-pin general-purpose port
// Assumes: pad inputs synchronous to core_clk; AHB-Lite single word transfers
// Notes: zero wait state slave, always OKAY
//
// Operation
// - software reads the sampled level of each pin in the input value register.
// - in general-purpose mode each pin is driven from the output value register.
// - a per-pin select field chooses one of four alternate outputs to drive the pin.
// - an alternate output drives the pin value directly while enable stays with the port.
// - the input path keeps working while the pin is an output.
// - each pin's input fans out to all peripherals at once.
// - a per-pin hardware select chooses which hardware master, if any, owns the pin.
// - a granted hardware master overrides the output and control registers.
// - after reset the debug pin is preset to the debug master, which drives test data out.
`timescale 1ns/1ps
`default_nettype none
`include "ppfm_defs.svh"

module ppfm_port_mux
    import ppfm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [15:0] alternate_output_one_out,
    input wire logic [15:0] alt2_out,
    input wire logic [15:0] alt3_out,
    input wire logic [15:0] alt4_out,
    input wire ppfm_hw_drive_t hw0_drive,
    input wire ppfm_hw_drive_t hw1_drive,
    input wire logic debug_test_data_out,
    input wire logic debug_test_data_oe,
    input wire logic [15:0] pad_in,
    output ppfm_pad_t pad_drive,
    output logic [15:0] periph_in,
    output logic [15:0] hw_master_input_path
);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [15:0] pin_output_value_reg, pin_output_value_next;
    logic [15:0] pin_input_value_reg, pin_input_value_next;
    logic [31:0] pin_control_lo_reg, pin_control_lo_next;
    logic [31:0] pin_control_hi_reg, pin_control_hi_next;
    logic [31:0] hw_select_reg, hw_select_next;
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] wr_addr_reg, wr_addr_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic [15:0] pad_value_reg, pad_value_next;
    logic [15:0] pad_enable_reg, pad_enable_next;
    logic [15:0] hw_in_reg, hw_in_next;

    // field extract helpers, used for every pin
    function automatic ppfm_fn_t fsel_of(input logic [31:0] lo, input logic [31:0] hi, input int pin);
        logic [63:0] all;
        all = {hi, lo};
        fsel_of = ppfm_fn_t'(all[pin*`PPFM_FSEL_STRIDE +: `PPFM_FSEL_W]);
    endfunction : fsel_of

    function automatic ppfm_hw_t hwsel_of(input logic [31:0] sel, input int pin);
        hwsel_of = ppfm_hw_t'(sel[pin*`PPFM_HWSEL_W +: `PPFM_HWSEL_W]);
    endfunction : hwsel_of

    // output enable bit of a pin's control field, shared by gpio and alternate functions
    function automatic logic oe_of(input logic [31:0] lo, input logic [31:0] hi, input int pin);
        logic [63:0] all;
        all = {hi, lo};
        oe_of = all[pin*`PPFM_FSEL_STRIDE + `PPFM_FSEL_OE_BIT];
    endfunction : oe_of

    // code 3 is reserved: treating it as no owner keeps a stray write from stealing a pin
    function automatic logic hw_owned(input ppfm_hw_t sel);
        hw_owned = (sel == PPFM_HW_MASTER0) || (sel == PPFM_HW_MASTER1);
    endfunction : hw_owned

    // address phase accepted only for a selected NONSEQ/SEQ transfer
    // idle and busy carry no transfer, so htrans[1] alone qualifies
    logic addr_valid;
    assign addr_valid = hsel && hready && htrans[1];

    // ----------------------------------------------------------------
    // bus slave: reads answer in the data phase, writes land at its end
    // ----------------------------------------------------------------
    always_comb begin
        pin_control_lo_next = pin_control_lo_reg;
        pin_control_hi_next = pin_control_hi_reg;
        hw_select_next = hw_select_reg;
        pin_output_value_next = pin_output_value_reg;
        wr_pend_next = addr_valid && hwrite;
        wr_addr_next = addr_valid ? haddr[7:0] : wr_addr_reg;
        hrdata_next = 32'h0000_0000;
        // writes commit at the end of the data phase, once hwdata stands
        if (wr_pend_reg) begin
            // software writes steer the mux
            unique case (wr_addr_reg)
                `PPFM_OFF_OUT: pin_output_value_next = hwdata[15:0];
                `PPFM_OFF_CTRL_LO: pin_control_lo_next = hwdata;
                `PPFM_OFF_CTRL_HI: pin_control_hi_next = hwdata;
                `PPFM_OFF_HWSEL: hw_select_next = hwdata;
                default: ;
            endcase
        end
        // unmapped offsets read zero and their writes are dropped
        if (addr_valid && !hwrite) begin
            unique case (haddr[7:0])
                `PPFM_OFF_OUT: hrdata_next = {16'h0000, pin_output_value_reg};
                `PPFM_OFF_IN: hrdata_next = {16'h0000, pin_input_value_reg};
                `PPFM_OFF_CTRL_LO: hrdata_next = pin_control_lo_reg;
                `PPFM_OFF_CTRL_HI: hrdata_next = pin_control_hi_reg;
                `PPFM_OFF_HWSEL: hrdata_next = hw_select_reg;
                default: hrdata_next = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin multiplexing
    // ----------------------------------------------------------------
    always_comb begin
        pin_input_value_next = pad_in;
        // gpio is the fallback for function codes 0 and 5 to 7
        pad_value_next = pin_output_value_reg;
        pad_enable_next = 16'h0000;
        for (int p = 0; p < `PPFM_PINS; p++) begin
            // gpio drives from the output register
            // alternate output chosen by the select field
            unique case (fsel_of(pin_control_lo_reg, pin_control_hi_reg, p))
                PPFM_FN_ALTERNATE_OUTPUT_ONE: pad_value_next[p] = alternate_output_one_out[p];
                PPFM_FN_ALT2: pad_value_next[p] = alt2_out[p];
                PPFM_FN_ALT3: pad_value_next[p] = alt3_out[p];
                PPFM_FN_ALT4: pad_value_next[p] = alt4_out[p];
                default: pad_value_next[p] = pin_output_value_reg[p];
            endcase
            // direction stays with the port, even for an alternate output
            pad_enable_next[p] = oe_of(pin_control_lo_reg, pin_control_hi_reg, p);
            unique case (hwsel_of(hw_select_reg, p))
                PPFM_HW_MASTER0: begin
                    pad_value_next[p] = hw0_drive.value[p];
                    pad_enable_next[p] = hw0_drive.enable[p];
                end
                PPFM_HW_MASTER1: begin
                    pad_value_next[p] = hw1_drive.value[p];
                    pad_enable_next[p] = hw1_drive.enable[p];
                end
                default: ;
            endcase
        end
        // debug master drives test data out on its pin
        // placed after the owner case so the debug port wins over master 1 on that pin
        if (hwsel_of(hw_select_reg, `PPFM_DEBUG_PIN) == PPFM_HW_MASTER1) begin
            pad_value_next[`PPFM_DEBUG_PIN] = debug_test_data_out;
            pad_enable_next[`PPFM_DEBUG_PIN] = debug_test_data_oe;
        end
        // only owned pins feed the shared master input path; other pins read zero there
        hw_in_next = 16'h0000;
        for (int p = 0; p < `PPFM_PINS; p++) begin
            hw_in_next[p] = hw_owned(hwsel_of(hw_select_reg, p)) ? pad_in[p] : 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // pads are registered: one cycle of latency buys glitch-free pad drive
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_output_value_reg <= `PPFM_OUT_RST;
            pin_input_value_reg <= 16'h0000;
            pin_control_lo_reg <= `PPFM_CTRL_RST;
            pin_control_hi_reg <= `PPFM_CTRL_RST;
            hw_select_reg <= `PPFM_HWSEL_RST;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_reg <= 32'h0000_0000;
            pad_value_reg <= 16'h0000;
            pad_enable_reg <= 16'h0000;
            hw_in_reg <= 16'h0000;
        end else begin
            pin_output_value_reg <= pin_output_value_next;
            pin_input_value_reg <= pin_input_value_next;
            pin_control_lo_reg <= pin_control_lo_next;
            pin_control_hi_reg <= pin_control_hi_next;
            hw_select_reg <= hw_select_next;
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            hrdata_reg <= hrdata_next;
            pad_value_reg <= pad_value_next;
            pad_enable_reg <= pad_enable_next;
            hw_in_reg <= hw_in_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign hrdata = hrdata_reg;
    // every access completes at once, so the slave never stretches a transfer
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign pad_drive.value = pad_value_reg;
    assign pad_drive.enable = pad_enable_reg;
    // one sampled input fans out to all peripherals
    assign periph_in = pin_input_value_reg;
    assign hw_master_input_path = hw_in_reg;

endmodule : ppfm_port_mux
`default_nettype wire

/* tb/ppfm_chk.sv */
// Purpose: port-level checks of the pin mux
// Assumes: sees only ppfm_port_mux ports
// Notes: the early window trusts the reset presets
`timescale 1ns/1ps
`default_nettype none
module ppfm_chk
    import ppfm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic debug_test_data_out,
    input wire logic debug_test_data_oe,
    input wire logic [15:0] pad_in,
    input wire ppfm_pad_t pad_drive,
    input wire logic [15:0] periph_in,
    input wire logic [15:0] hw_master_input_path
);
    logic [2:0] age_reg;
    logic [2:0] age_next;
    logic early;
    // edges since reset release; $past is stale before age 1
    always_comb age_next = (age_reg == 3'h7) ? age_reg : age_reg + 3'h1;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) age_reg <= 3'h0;
        else age_reg <= age_next;
    end
    assign early = (age_reg != 3'h0) && (age_reg < 3'h4);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
    a_input_sample: assert property (age_reg != 3'h0 |-> periph_in == $past(pad_in))
        else $error("input sample wrong");
    a_input_subset: assert property (age_reg != 3'h0 |-> (hw_master_input_path & ~periph_in) == 16'h0)
        else $error("master input not from pin");
    a_rdata_idle: assert property (age_reg != 3'h0 && !$past(hsel && hready && htrans[1] && !hwrite)
        |-> hrdata == 32'h0) else $error("read data outside data phase");
    a_debug_value: assert property (early |-> pad_drive.value[1] == $past(debug_test_data_out))
        else $error("debug pin value wrong");
    a_debug_enable: assert property (early |-> pad_drive.enable[1] == $past(debug_test_data_oe))
        else $error("debug pin enable wrong");
    a_debug_input: assert property (early |-> hw_master_input_path == {14'h0, $past(pad_in[1]), 1'b0})
        else $error("debug pin input path wrong");
    a_gpio_idle: assert property (early |-> ((pad_drive.value | pad_drive.enable) & 16'hFFFD) == 16'h0)
        else $error("idle pins driven");
endmodule : ppfm_chk
bind ppfm_port_mux ppfm_chk chk_i (.core_clk(core_clk), .rst(rst), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .debug_test_data_out(debug_test_data_out), .debug_test_data_oe(debug_test_data_oe), .pad_in(pad_in),
    .pad_drive(pad_drive), .periph_in(periph_in), .hw_master_input_path(hw_master_input_path));
`default_nettype wire

/* tb/ppfm_periph_model.sv */
// Purpose: peripherals and masters facing the pin mux
// Assumes: new values only while step is high
// Notes: held steady otherwise so checks see settled inputs
`timescale 1ns/1ps
`default_nettype none
module ppfm_periph_model
    import ppfm_pkg::*;
(
    input wire logic core_clk,
    input wire logic step,
    output logic [15:0] alternate_output_one_out,
    output logic [15:0] alt2_out,
    output logic [15:0] alt3_out,
    output logic [15:0] alt4_out,
    output ppfm_hw_drive_t hw0_drive,
    output ppfm_hw_drive_t hw1_drive,
    output logic debug_test_data_out,
    output logic debug_test_data_oe
);
    // one process owns every output: quiet at start, fresh random values on each step
    initial begin
        {alternate_output_one_out, alt2_out, alt3_out, alt4_out, hw0_drive, hw1_drive} = '0;
        {debug_test_data_out, debug_test_data_oe} = 2'h0;
        forever begin
            @(posedge core_clk);
            if (step) begin
                {alternate_output_one_out, alt2_out} <= $urandom;
                {alt3_out, alt4_out} <= $urandom;
                hw0_drive <= $urandom;
                hw1_drive <= $urandom;
                {debug_test_data_out, debug_test_data_oe} <= 2'($urandom);
            end
        end
    end
endmodule : ppfm_periph_model
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: self-checking bench of the pin mux
// Assumes: zero wait slave, registered outputs
// Notes: all pins share one setting per sweep
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ppfm_pkg::*;
;
    logic core_clk, rst, hsel, hwrite, step, hreadyout, hresp, dbo, dboe;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, hs;
    logic [2:0] hsize;
    logic [3:0] nib;
    logic [15:0] a1, a2, a3, a4, pad_in, periph_in, hwin, outv;
    ppfm_hw_drive_t hw0, hw1;
    ppfm_pad_t pad_drive;
    int n_fail, checks;
    ppfm_port_mux dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .alternate_output_one_out(a1), .alt2_out(a2), .alt3_out(a3), .alt4_out(a4),
        .hw0_drive(hw0), .hw1_drive(hw1), .debug_test_data_out(dbo), .debug_test_data_oe(dboe),
        .pad_in(pad_in), .pad_drive(pad_drive), .periph_in(periph_in), .hw_master_input_path(hwin));
    ppfm_periph_model peri (.core_clk(core_clk), .step(step), .alternate_output_one_out(a1), .alt2_out(a2), .alt3_out(a3),
        .alt4_out(a4), .hw0_drive(hw0), .hw1_drive(hw1), .debug_test_data_out(dbo), .debug_test_data_oe(dboe));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic results;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : chk
    // one single word transfer; the address phase holds until hready
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus
    // hardware masters win over function select; pin 1 of master 1 is the debug port
    function automatic ppfm_pad_t exp_pad(input logic [3:0] n, input logic [1:0] h);
        ppfm_pad_t p;
        p.value = (n[2:0] == 3'h1) ? a1 : (n[2:0] == 3'h2) ? a2 : (n[2:0] == 3'h3) ? a3 :
            (n[2:0] == 3'h4) ? a4 : outv;
        p.enable = {16{n[3]}};
        if (h == 2'h1) p = ppfm_pad_t'(hw0);
        if (h == 2'h2) p = ppfm_pad_t'({hw1.value[15:2], dbo, hw1.value[0], hw1.enable[15:2], dboe, hw1.enable[0]});
        return p;
    endfunction : exp_pad
    initial begin
        #50000;
        n_fail++;
        results();
    end
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, pad_in, outv, n_fail, checks} = '0;
        // peripherals and pads move from the start so the early debug checks see live values
        step = 1'b1;
        hsize = 3'h2;
        rst = 1'b1;
        rd = $urandom(32'h66B7);
        repeat (6) begin
            @(posedge core_clk);
            pad_in <= 16'($urandom);
        end
        rst <= 1'b0;
        repeat (5) begin
            @(posedge core_clk);
            pad_in <= 16'($urandom);
        end
        bus(8'h10, 1'b0, 32'h0, rd);
        chk("hwsel_rst", 32'h0000_0008, rd);
        bus(8'h08, 1'b0, 32'h0, rd);
        chk("ctrl_rst", 32'h0, rd);
        bus(8'h20, 1'b1, 32'hFFFF_FFFF, rd);
        bus(8'h20, 1'b0, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        $display("test reset done");
        for (int m = 0; m < 20; m++) begin
            hs = 2'(m / 5);
            nib = {1'($urandom), 3'(m % 5)};
            outv = 16'($urandom);
            step <= 1'b1;
            pad_in <= 16'($urandom);
            bus(8'h00, 1'b1, {16'h0, outv}, rd);
            bus(8'h08, 1'b1, {8{nib}}, rd);
            bus(8'h0C, 1'b1, {8{nib}}, rd);
            bus(8'h10, 1'b1, {16{hs}}, rd);
            step <= 1'b0;
            repeat (2) @(posedge core_clk);
            chk("pad_drive", exp_pad(nib, hs), pad_drive);
            chk("periph_in", {16'h0, pad_in}, {16'h0, periph_in});
            chk("hw_input", {16'h0, (hs == 2'h1 || hs == 2'h2) ? pad_in : 16'h0}, {16'h0, hwin});
            bus(8'h04, 1'b0, 32'h0, rd);
            chk("in_reg", {16'h0, pad_in}, rd);
            bus(8'h00, 1'b0, 32'h0, rd);
            chk("out_reg", {16'h0, outv}, rd);
            $display("test sweep %0d done", m);
        end
        results();
    end
endmodule : tb_top
`default_nettype wire
